//--- core/cprf_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the CPU register file
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CPRF_MAP_SVH
`define CPRF_MAP_SVH

// ==========================================================================
// Condition-code field positions
`define CPRF_CC_IMASK 3'd7
`define CPRF_CC_USER 3'd6
`define CPRF_CC_HALF 3'd5
`define CPRF_CC_USER4 3'd4
`define CPRF_CC_NEG 3'd3
`define CPRF_CC_ZERO 3'd2
`define CPRF_CC_OVF 3'd1
`define CPRF_CC_CARRY 3'd0

// ==========================================================================
// Reset and address constants
`define CPRF_PC_RESET 24'h000000
`define CPRF_ADDR_MASK 24'h00ffff
`define CPRF_CC_RESET 8'h80
`define CPRF_SP_INDEX 3'd7

// ==========================================================================
// Execution latencies in states
`define CPRF_ADD_STATES 5'd2
`define CPRF_MUL8_STATES 5'd14
`define CPRF_MUL16_STATES 5'd22
`define CPRF_DIV8_STATES 5'd14
`define CPRF_DIV16_STATES 5'd22

`endif

//--- core/cprf_pkg.sv
// Purpose: Types of the CPU register file
// Assumes: Used together with cprf_map.svh
// Notes: Types only
package cprf_pkg;

  // ========================================================================
  // Access width of a general register view
  typedef enum logic [1:0] {
    CPRF_W_LONG,
    CPRF_W_EXT,
    CPRF_W_LOW16,
    CPRF_W_BYTE
  } cprf_width_t;

  // ========================================================================
  // Register-register operation codes
  typedef enum logic [2:0] {
    CPRF_OP_ADD,
    CPRF_OP_SUB,
    CPRF_OP_CMP,
    CPRF_OP_NEG,
    CPRF_OP_MULU,
    CPRF_OP_DIVU
  } cprf_op_t;

  typedef enum logic [1:0] {
    CPRF_SZ_B,
    CPRF_SZ_W,
    CPRF_SZ_L
  } cprf_size_t;

  typedef enum logic [2:0] {
    CPRF_CCOP_NONE,
    CPRF_CCOP_LOAD,
    CPRF_CCOP_AND,
    CPRF_CCOP_OR,
    CPRF_CCOP_XOR
  } cprf_ccop_t;

  typedef enum {
    CPRF_ST_IDLE,
    CPRF_ST_BUSY
  } cprf_state_t;

endpackage

//--- core/cprf_alu.sv
// Purpose: Add and subtract with flag generation at byte, word and long sizes
// Assumes: Operands right-aligned, upper bits ignored for narrow sizes
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cprf_map.svh"

module cprf_alu
  import cprf_pkg::*;
(
  input wire logic [31:0] a_in,
  input wire logic [31:0] b_in,
  input wire logic sub_in,
  input wire cprf_size_t size_in,
  output logic [31:0] res_out,
  output logic half_out,
  output logic neg_out,
  output logic zero_out,
  output logic ovf_out,
  output logic carry_out
);

  logic [32:0] sum;
  logic [31:0] bop;
  logic [31:0] hsum;
  logic [4:0] hsum_b;
  logic [12:0] hsum_w;
  logic [28:0] hsum_l;
  logic sa;
  logic sb;
  logic sr;

  always_comb
  begin
    bop = sub_in ? ~b_in : b_in;
    sum = {1'b0, a_in} + {1'b0, bop} + {32'h0, sub_in};
    hsum_b = {1'b0, a_in[3:0]} + {1'b0, bop[3:0]} + {4'h0, sub_in};
    hsum_w = {1'b0, a_in[11:0]} + {1'b0, bop[11:0]} + {12'h0, sub_in};
    hsum_l = {1'b0, a_in[27:0]} + {1'b0, bop[27:0]} + {28'h0, sub_in};
    hsum = 32'h0;
    res_out = sum[31:0];
    sa = a_in[31];
    sb = bop[31];
    sr = sum[31];
    carry_out = sum[32] ^ sub_in;
    half_out = hsum_l[28] ^ sub_in;
    case (size_in)
      CPRF_SZ_B:
      begin
        res_out = {24'h0, sum[7:0]};
        sa = a_in[7];
        sb = bop[7];
        sr = sum[7];
        hsum = {24'h0, a_in[7:0]} + {24'h0, bop[7:0]} + {31'h0, sub_in};
        carry_out = hsum[8] ^ sub_in;
        half_out = hsum_b[4] ^ sub_in;
      end
      CPRF_SZ_W:
      begin
        res_out = {16'h0, sum[15:0]};
        sa = a_in[15];
        sb = bop[15];
        sr = sum[15];
        hsum = {16'h0, a_in[15:0]} + {16'h0, bop[15:0]} + {31'h0, sub_in};
        carry_out = hsum[16] ^ sub_in;
        half_out = hsum_w[12] ^ sub_in;
      end
      default:
      begin
      end
    endcase
    neg_out = sr;
    zero_out = (res_out == 32'h0);
    ovf_out = (sa == sb) && (sr != sa);
  end

endmodule

`default_nettype wire

//--- core/cprf_core.sv
// Purpose: CPU programmer-visible state: general registers, program counter, condition codes
// Assumes: Decode and exception sequencing drive the request ports; states are clock cycles
// Notes: Clock enable low freezes all state
`timescale 1ns/1ps
`default_nettype none
`include "cprf_map.svh"

module cprf_core
  import cprf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Register read ports
  input wire logic [3:0] rd_a_sel_in,
  input wire cprf_width_t rd_a_width_in,
  output logic [31:0] rd_a_data_out,
  input wire logic [3:0] rd_b_sel_in,
  input wire cprf_width_t rd_b_width_in,
  output logic [31:0] rd_b_data_out,
  // Register write port
  input wire logic wr_en_in,
  input wire logic [3:0] wr_sel_in,
  input wire cprf_width_t wr_width_in,
  input wire logic [31:0] wr_data_in,
  // Stack pointer
  output logic [31:0] stack_ptr_out,
  // Program counter
  input wire logic pc_load_in,
  input wire logic [23:0] pc_load_val_in,
  input wire logic pc_advance_in,
  input wire logic reset_seq_in,
  input wire logic [23:0] reset_vector_in,
  output logic [23:0] pc_out,
  output logic [23:0] fetch_addr_out,
  // Condition codes
  input wire cprf_ccop_t cc_op_in,
  input wire logic [7:0] cc_imm_in,
  input wire logic exc_start_in,
  input wire logic cc_bit_wr_in,
  input wire logic cc_bit_val_in,
  input wire logic cc_shift_wr_in,
  input wire logic cc_shift_val_in,
  output logic [7:0] cc_flags_out,
  output logic [3:0] branch_flags_out,
  // Interrupt gate
  input wire logic irq_req_in,
  input wire logic nmi_req_in,
  output logic irq_accept_out,
  output logic nmi_accept_out,
  // Operation request
  input wire logic op_start_in,
  input wire cprf_op_t op_in,
  input wire cprf_size_t op_size_in,
  input wire logic [2:0] op_dst_in,
  input wire logic [2:0] op_src_in,
  output logic op_busy_out,
  output logic op_done_out
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0][31:0] gr;
    logic [23:0] pc;
    logic [7:0] cc;
    cprf_state_t st;
    logic [4:0] cnt;
    cprf_op_t op;
    cprf_size_t size;
    logic [2:0] dst;
    logic [31:0] result;
    logic [7:0] res_cc;
    logic done;
  } cprf_regs_t;

  cprf_regs_t regs_ff;
  cprf_regs_t nxt_regs;

  logic [31:0] alu_a;
  logic [31:0] alu_b;
  logic [31:0] alu_res;
  logic alu_h;
  logic alu_n;
  logic alu_z;
  logic alu_v;
  logic alu_c;

  // ========================================================================
  // Views
  // Select codes: bit 3 picks the high byte (bits 15:8) in byte view, bits 2:0 the register
  function automatic logic [31:0] view_read(input logic [7:0][31:0] gr, input logic [3:0] sel,
                                            input cprf_width_t w);
    logic [31:0] r;
    r = gr[sel[2:0]];
    case (w)
      CPRF_W_LONG: view_read = r;
      CPRF_W_EXT: view_read = {16'h0, r[31:16]};
      CPRF_W_LOW16: view_read = {16'h0, r[15:0]};
      CPRF_W_BYTE: view_read = sel[3] ? {24'h0, r[15:8]} : {24'h0, r[7:0]};
      default: view_read = r;
    endcase
  endfunction

  function automatic logic [31:0] view_merge(input logic [31:0] old, input logic hi,
                                             input cprf_width_t w, input logic [31:0] d);
    case (w)
      CPRF_W_LONG: view_merge = d;
      CPRF_W_EXT: view_merge = {d[15:0], old[15:0]};
      CPRF_W_LOW16: view_merge = {old[31:16], d[15:0]};
      CPRF_W_BYTE: view_merge = hi ? {old[31:16], d[7:0], old[7:0]} : {old[31:8], d[7:0]};
      default: view_merge = old;
    endcase
  endfunction

  function automatic cprf_width_t size_view(input cprf_size_t s);
    case (s)
      CPRF_SZ_B: size_view = CPRF_W_BYTE;
      CPRF_SZ_W: size_view = CPRF_W_LOW16;
      default: size_view = CPRF_W_LONG;
    endcase
  endfunction

  // ========================================================================
  // Adder with flags
  always_comb
  begin
    alu_a = view_read(regs_ff.gr, {1'b0, op_dst_in}, size_view(op_size_in));
    alu_b = view_read(regs_ff.gr, {1'b0, op_src_in}, size_view(op_size_in));
    if (op_in == CPRF_OP_NEG)
    begin
      alu_b = alu_a;
      alu_a = 32'h0;
    end
  end

  cprf_alu u_alu (
    .a_in(alu_a),
    .b_in(alu_b),
    .sub_in(op_in != CPRF_OP_ADD),
    .size_in(op_size_in),
    .res_out(alu_res),
    .half_out(alu_h),
    .neg_out(alu_n),
    .zero_out(alu_z),
    .ovf_out(alu_v),
    .carry_out(alu_c)
  );

  // ========================================================================
  // Next state
  always_comb
  begin
    logic [31:0] mres;
    logic [31:0] dsrc;
    logic [31:0] dend;
    logic [15:0] q;
    logic [15:0] rm;
    mres = 32'h0;
    dsrc = 32'h0;
    dend = 32'h0;
    q = 16'h0;
    rm = 16'h0;
    nxt_regs = regs_ff;
    nxt_regs.done = 1'b0;
    // Register writes: any view on any register, no global mode
    if (wr_en_in)
    begin
      nxt_regs.gr[wr_sel_in[2:0]] = view_merge(regs_ff.gr[wr_sel_in[2:0]], wr_sel_in[3],
                                               wr_width_in, wr_data_in);
    end
    // Operation sequencer
    case (regs_ff.st)
      CPRF_ST_IDLE:
      begin
        if (op_start_in)
        begin
          nxt_regs.op = op_in;
          nxt_regs.size = op_size_in;
          nxt_regs.dst = op_dst_in;
          nxt_regs.res_cc = regs_ff.cc;
          nxt_regs.st = CPRF_ST_BUSY;
          case (op_in)
            CPRF_OP_MULU:
            begin
              if (op_size_in == CPRF_SZ_B)
              begin
                mres = {16'h0, 16'(alu_a[7:0]) * 16'(alu_b[7:0])};
                nxt_regs.cnt = `CPRF_MUL8_STATES - 5'd1;
                nxt_regs.result = view_merge(regs_ff.gr[op_dst_in], 1'b0, CPRF_W_LOW16, mres);
              end
              else
              begin
                mres = 32'(alu_a[15:0]) * 32'(alu_b[15:0]);
                nxt_regs.cnt = `CPRF_MUL16_STATES - 5'd1;
                nxt_regs.result = mres;
              end
            end
            CPRF_OP_DIVU:
            begin
              // Zero divisor leaves quotient all ones; caller handles exception
              if (op_size_in == CPRF_SZ_B)
              begin
                dend = {16'h0, regs_ff.gr[op_dst_in][15:0]};
                dsrc = {24'h0, alu_b[7:0]};
                q = (dsrc == 32'h0) ? 16'hffff : 16'(dend / dsrc);
                rm = (dsrc == 32'h0) ? dend[15:0] : 16'(dend % dsrc);
                nxt_regs.cnt = `CPRF_DIV8_STATES - 5'd1;
                nxt_regs.result = {regs_ff.gr[op_dst_in][31:16], rm[7:0], q[7:0]};
              end
              else
              begin
                dend = regs_ff.gr[op_dst_in];
                dsrc = {16'h0, alu_b[15:0]};
                q = (dsrc == 32'h0) ? 16'hffff : 16'(dend / dsrc);
                rm = (dsrc == 32'h0) ? dend[15:0] : 16'(dend % dsrc);
                nxt_regs.cnt = `CPRF_DIV16_STATES - 5'd1;
                nxt_regs.result = {rm, q};
              end
            end
            default:
            begin
              nxt_regs.cnt = `CPRF_ADD_STATES - 5'd1;
              nxt_regs.result = view_merge(regs_ff.gr[op_dst_in], 1'b0, size_view(op_size_in), alu_res);
              nxt_regs.res_cc[`CPRF_CC_HALF] = alu_h;
              nxt_regs.res_cc[`CPRF_CC_NEG] = alu_n;
              nxt_regs.res_cc[`CPRF_CC_ZERO] = alu_z;
              nxt_regs.res_cc[`CPRF_CC_OVF] = alu_v;
              nxt_regs.res_cc[`CPRF_CC_CARRY] = alu_c;
            end
          endcase
        end
      end
      CPRF_ST_BUSY:
      begin
        nxt_regs.cnt = regs_ff.cnt - 5'd1;
        if (regs_ff.cnt == 5'd1)
        begin
          nxt_regs.st = CPRF_ST_IDLE;
          nxt_regs.done = 1'b1;
          if (regs_ff.op != CPRF_OP_CMP)
          begin
            nxt_regs.gr[regs_ff.dst] = regs_ff.result;
          end
          // Multiply and divide leave flags unchanged here
          nxt_regs.cc = regs_ff.res_cc;
        end
      end
      default:
      begin
        nxt_regs.st = CPRF_ST_IDLE;
      end
    endcase
    // Flag register transfer and logic
    case (cc_op_in)
      CPRF_CCOP_LOAD: nxt_regs.cc = cc_imm_in;
      CPRF_CCOP_AND: nxt_regs.cc = regs_ff.cc & cc_imm_in;
      CPRF_CCOP_OR: nxt_regs.cc = regs_ff.cc | cc_imm_in;
      CPRF_CCOP_XOR: nxt_regs.cc = regs_ff.cc ^ cc_imm_in;
      default:
      begin
      end
    endcase
    if (cc_bit_wr_in)
    begin
      nxt_regs.cc[`CPRF_CC_CARRY] = cc_bit_val_in;
    end
    if (cc_shift_wr_in)
    begin
      nxt_regs.cc[`CPRF_CC_CARRY] = cc_shift_val_in;
    end
    // Program counter
    if (pc_load_in)
    begin
      nxt_regs.pc = pc_load_val_in;
    end
    else if (pc_advance_in)
    begin
      nxt_regs.pc = regs_ff.pc + 24'h000002;
    end
    nxt_regs.pc = nxt_regs.pc & `CPRF_ADDR_MASK;
    // Exception entry overrides the mask last so it always wins
    if (exc_start_in || reset_seq_in)
    begin
      nxt_regs.cc[`CPRF_CC_IMASK] = 1'b1;
    end
    if (reset_seq_in)
    begin
      nxt_regs.pc = reset_vector_in & `CPRF_ADDR_MASK;
    end
  end

  // ========================================================================
  // Registers
  // Flags other than the mask are undefined after reset; zero keeps simulation clean
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      regs_ff <= '0;
      regs_ff.pc <= `CPRF_PC_RESET;
      regs_ff.cc <= `CPRF_CC_RESET;
      regs_ff.st <= CPRF_ST_IDLE;
    end
    else if (clk_en_in)
    begin
      regs_ff <= nxt_regs;
    end
  end

  // ========================================================================
  // Outputs
  always_comb
  begin
    rd_a_data_out = view_read(regs_ff.gr, rd_a_sel_in, rd_a_width_in);
    rd_b_data_out = view_read(regs_ff.gr, rd_b_sel_in, rd_b_width_in);
    stack_ptr_out = regs_ff.gr[`CPRF_SP_INDEX];
    pc_out = regs_ff.pc;
    fetch_addr_out = {regs_ff.pc[23:1], 1'b0};
    cc_flags_out = regs_ff.cc;
    branch_flags_out = regs_ff.cc[3:0];
    irq_accept_out = irq_req_in && !regs_ff.cc[`CPRF_CC_IMASK];
    nmi_accept_out = nmi_req_in;
    op_busy_out = (regs_ff.st == CPRF_ST_BUSY);
    op_done_out = regs_ff.done;
  end

endmodule

`default_nettype wire

//--- bench/cprf_checker.sv
// Purpose: Port assertions for the CPU register file
// Assumes: Bound to cprf_core, one clock domain
// Notes: Slow-op timing assumes clock enable stays high
`timescale 1ns/1ps
`default_nettype none
`include "cprf_map.svh"
module cprf_checker
  import cprf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic pc_advance_in,
  input wire logic pc_load_in,
  input wire logic reset_seq_in,
  input wire logic [23:0] reset_vector_in,
  input wire logic [23:0] pc_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic exc_start_in,
  input wire logic [7:0] cc_flags_out,
  input wire logic [3:0] branch_flags_out,
  input wire logic irq_req_in,
  input wire logic nmi_req_in,
  input wire logic irq_accept_out,
  input wire logic nmi_accept_out,
  input wire logic op_start_in,
  input wire cprf_op_t op_in,
  input wire cprf_size_t op_size_in,
  input wire logic op_busy_out,
  input wire logic op_done_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // Operation timing
  sequence s_fast;
    op_start_in && !op_busy_out && clk_en_in && op_in inside {CPRF_OP_ADD, CPRF_OP_SUB, CPRF_OP_CMP, CPRF_OP_NEG};
  endsequence
  sequence s_slow(sz);
    op_start_in && !op_busy_out && clk_en_in && op_in inside {CPRF_OP_MULU, CPRF_OP_DIVU} && op_size_in == sz;
  endsequence
  a_add_two_states: assert property (s_fast ##1 clk_en_in |-> op_busy_out && !op_done_out ##1 op_done_out)
    else $error("add latency wrong");
  a_short_mul_time: assert property (s_slow(CPRF_SZ_B) |-> ##14 op_done_out)
    else $error("byte multiply or divide latency wrong");
  a_long_mul_time: assert property (s_slow(CPRF_SZ_W) |-> ##22 op_done_out)
    else $error("word multiply or divide latency wrong");
  a_done_one_cycle: assert property (op_done_out && clk_en_in |=> !op_done_out)
    else $error("done longer than one cycle");
  // ==========================================================================
  // Counter, flags and interrupt gate
  a_fetch_even_addr: assert property (fetch_addr_out == {pc_out[23:1], 1'b0})
    else $error("fetch address bit zero set");
  a_reset_vector_load: assert property (reset_seq_in && clk_en_in |=> pc_out == ($past(reset_vector_in) & `CPRF_ADDR_MASK))
    else $error("reset vector not loaded");
  a_pc_step_two: assert property (pc_advance_in && !pc_load_in && !reset_seq_in && clk_en_in
    |=> pc_out == (($past(pc_out) + 24'h000002) & `CPRF_ADDR_MASK))
    else $error("counter advance wrong");
  a_exc_sets_mask: assert property (exc_start_in && clk_en_in |=> cc_flags_out[7])
    else $error("mask not set by exception");
  a_irq_mask_gate: assert property (irq_accept_out == (irq_req_in && !cc_flags_out[7]))
    else $error("interrupt gate wrong");
  a_nmi_always_taken: assert property (nmi_accept_out == nmi_req_in)
    else $error("non-maskable gate wrong");
  a_branch_flag_map: assert property (branch_flags_out == cc_flags_out[3:0])
    else $error("branch flags wrong");
endmodule
bind cprf_core cprf_checker chk (.*);
`default_nettype wire

//--- bench/cprf_exec_model.sv
// Purpose: Execute-stage model issuing register-register operations
// Assumes: Start taken only while busy is low
// Notes: Latency counted in edges from the start edge
`timescale 1ns/1ps
`default_nettype none
module cprf_exec_model
  import cprf_pkg::*;
(
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic done_in,
  output logic start_out,
  output cprf_op_t op_out,
  output cprf_size_t size_out,
  output logic [2:0] dst_out,
  output logic [2:0] src_out
);
  initial
  begin
    start_out = 1'b0;
    op_out = CPRF_OP_ADD;
    size_out = CPRF_SZ_B;
    dst_out = 3'h0;
    src_out = 3'h1;
  end
  // ==========================================================================
  // One operation, waits out busy first so the start is never refused
  task automatic run(input cprf_op_t o, input cprf_size_t s, input logic [2:0] d, input logic [2:0] r,
    output int lat);
    while (busy_in)
    begin
      @(posedge clk_in);
      #1;
    end
    op_out = o;
    size_out = s;
    dst_out = d;
    src_out = r;
    start_out = 1'b1;
    @(posedge clk_in);
    #1;
    start_out = 1'b0;
    lat = 1;
    while (done_in !== 1'b1 && lat < 40)
    begin
      @(posedge clk_in);
      #1;
      lat++;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench of the CPU register file
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Operation table first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cprf_pkg::*;
;
  typedef struct {cprf_op_t op; cprf_size_t sz; logic [31:0] a, b, res; logic [5:0] cc; bit f; int lat;} cprf_row_t;
  cprf_row_t rows[9] = '{
    '{CPRF_OP_ADD, CPRF_SZ_B, 32'h12345678, 32'h8, 32'h12345680, 6'h2a, 1, 2},
    '{CPRF_OP_SUB, CPRF_SZ_W, 32'h1000, 32'h1, 32'hfff, 6'h20, 1, 2},
    '{CPRF_OP_CMP, CPRF_SZ_L, 32'h5, 32'h5, 32'h5, 6'h04, 1, 2},
    '{CPRF_OP_NEG, CPRF_SZ_B, 32'h1, 32'h1, 32'hff, 6'h29, 1, 2},
    '{CPRF_OP_ADD, CPRF_SZ_L, 32'hffffffff, 32'h1, 32'h0, 6'h25, 1, 2},
    '{CPRF_OP_MULU, CPRF_SZ_B, 32'habcd0012, 32'h10, 32'habcd0120, 6'h0, 0, 14},
    '{CPRF_OP_MULU, CPRF_SZ_W, 32'h1000, 32'h100, 32'h100000, 6'h0, 0, 22},
    '{CPRF_OP_DIVU, CPRF_SZ_B, 32'h64, 32'h7, 32'h20e, 6'h0, 0, 14},
    '{CPRF_OP_DIVU, CPRF_SZ_W, 32'h10001, 32'h2, 32'h18000, 6'h0, 0, 22}};
  cprf_ccop_t ccops[5] = '{CPRF_CCOP_LOAD, CPRF_CCOP_OR, CPRF_CCOP_AND, CPRF_CCOP_XOR, CPRF_CCOP_NONE};
  logic [7:0] ccimm[5] = '{8'h40, 8'h11, 8'hf0, 8'hff, 8'h00};
  logic [7:0] ccexp[5] = '{8'h40, 8'h51, 8'h50, 8'haf, 8'haf};
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr_en = 1'b0, pc_load = 1'b0, pc_adv = 1'b0, rseq = 1'b0;
  logic exc = 1'b0, bit_wr = 1'b0, bit_val = 1'b0, sh_wr = 1'b0, sh_val = 1'b0, irq = 1'b0, nmi = 1'b0;
  logic [3:0] a_sel = 4'h0, b_sel = 4'h0, w_sel = 4'h0;
  cprf_width_t a_w = CPRF_W_LONG, b_w = CPRF_W_LONG, w_w = CPRF_W_LONG;
  logic [31:0] w_data = 32'h0;
  logic [23:0] pc_val = 24'h0, vec = 24'h0;
  cprf_ccop_t cc_op = CPRF_CCOP_NONE;
  logic [7:0] cc_imm = 8'h00;
  logic [31:0] a_data, b_data, sp;
  logic [23:0] pc, fetch;
  logic [7:0] cc;
  logic [3:0] bflags;
  logic irq_acc, nmi_acc, start, busy, done;
  logic [2:0] dst, src;
  cprf_op_t op;
  cprf_size_t size;
  int mismatches = 0, comparisons = 0, cycles = 0, lat;
  initial
  begin
    forever #4 clk = ~clk;
  end
  cprf_exec_model model (.clk_in(clk), .busy_in(busy), .done_in(done), .start_out(start), .op_out(op),
    .size_out(size), .dst_out(dst), .src_out(src));
  cprf_core dut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(clk_en), .rd_a_sel_in(a_sel),
    .rd_a_width_in(a_w), .rd_a_data_out(a_data), .rd_b_sel_in(b_sel), .rd_b_width_in(b_w),
    .rd_b_data_out(b_data), .wr_en_in(wr_en), .wr_sel_in(w_sel), .wr_width_in(w_w), .wr_data_in(w_data),
    .stack_ptr_out(sp), .pc_load_in(pc_load), .pc_load_val_in(pc_val), .pc_advance_in(pc_adv),
    .reset_seq_in(rseq), .reset_vector_in(vec), .pc_out(pc), .fetch_addr_out(fetch), .cc_op_in(cc_op),
    .cc_imm_in(cc_imm), .exc_start_in(exc), .cc_bit_wr_in(bit_wr), .cc_bit_val_in(bit_val),
    .cc_shift_wr_in(sh_wr), .cc_shift_val_in(sh_val), .cc_flags_out(cc), .branch_flags_out(bflags),
    .irq_req_in(irq), .nmi_req_in(nmi), .irq_accept_out(irq_acc), .nmi_accept_out(nmi_acc),
    .op_start_in(start), .op_in(op), .op_size_in(size), .op_dst_in(dst), .op_src_in(src),
    .op_busy_out(busy), .op_done_out(done));
  // ==========================================================================
  // Shared tasks
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] s, input cprf_width_t w, input logic [31:0] d);
    w_sel = s;
    w_w = w;
    w_data = d;
    wr_en = 1'b1;
    step();
    wr_en = 1'b0;
    step();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("mask after reset", 32'h1, cc[7]);
    foreach (rows[i])
    begin
      wr(4'h0, CPRF_W_LONG, rows[i].a);
      wr(4'h1, CPRF_W_LONG, rows[i].b);
      model.run(rows[i].op, rows[i].sz, 3'h0, 3'h1, lat);
      chk("latency", rows[i].lat, lat);
      chk("result", rows[i].res, a_data);
      if (rows[i].f)
        chk("flags", rows[i].cc, cc[5:0]);
    end
    wr(4'h3, CPRF_W_LONG, 32'h11223344);
    wr(4'h3, CPRF_W_EXT, 32'haaaa);
    wr(4'hb, CPRF_W_BYTE, 32'h55);
    wr(4'h3, CPRF_W_BYTE, 32'h66);
    a_sel = 4'h3;
    b_sel = 4'hb;
    b_w = CPRF_W_BYTE;
    #1;
    chk("long view", 32'haaaa5566, a_data);
    chk("high byte view", 32'h55, b_data);
    a_w = CPRF_W_EXT;
    b_sel = 4'h3;
    b_w = CPRF_W_LOW16;
    #1;
    chk("extended view", 32'haaaa, a_data);
    chk("low half view", 32'h5566, b_data);
    wr(4'h7, CPRF_W_LONG, 32'hdeadbeef);
    chk("stack pointer", 32'hdeadbeef, sp);
    vec = 24'h123457;
    rseq = 1'b1;
    step();
    rseq = 1'b0;
    chk("counter", 32'h3457, pc);
    chk("fetch", 32'h3456, fetch);
    pc_adv = 1'b1;
    step();
    clk_en = 1'b0;
    step();
    step();
    chk("frozen counter", 32'h3459, pc);
    clk_en = 1'b1;
    pc_adv = 1'b0;
    pc_load = 1'b1;
    pc_val = 24'h00fffe;
    step();
    pc_load = 1'b0;
    pc_adv = 1'b1;
    step();
    pc_adv = 1'b0;
    chk("wrapped counter", 32'h0, pc);
    for (int i = 0; i < 5; i++)
    begin
      cc_op = ccops[i];
      cc_imm = ccimm[i];
      step();
      chk("flag op", ccexp[i], cc);
    end
    chk("branch flags", 32'hf, bflags);
    irq = 1'b1;
    nmi = 1'b1;
    #1;
    chk("masked irq", 32'h0, irq_acc);
    chk("nmi", 32'h1, nmi_acc);
    cc_op = CPRF_CCOP_LOAD;
    step();
    chk("open irq", 32'h1, irq_acc);
    exc = 1'b1;
    step();
    exc = 1'b0;
    // Logic op clears carry so only the bit write can set it
    cc_op = CPRF_CCOP_AND;
    cc_imm = 8'hfe;
    bit_wr = 1'b1;
    bit_val = 1'b1;
    chk("exception mask", 32'h80, cc);
    step();
    bit_wr = 1'b0;
    sh_wr = 1'b1;
    cc_op = CPRF_CCOP_LOAD;
    cc_imm = 8'h01;
    chk("bit accumulator", 32'h81, cc);
    step();
    sh_wr = 1'b0;
    cc_op = CPRF_CCOP_NONE;
    chk("shift carry", 32'h0, cc);
    // Mask is clear here, so a second reset must set it again
    rst_n = 1'b0;
    #1;
    chk("mask after second reset", 32'h1, cc[7]);
    step();
    rst_n = 1'b1;
    step();
    chk("busy after second reset", 32'h0, busy);
    wrap_up();
  end
endmodule
`default_nettype wire
